// ==== ssrb_defines.vh ====
// register indices, field positions, reset values and codes for the safety status bank
`ifndef SSRB_DEFINES_VH
`define SSRB_DEFINES_VH

// register select codes on the read port
`define SSRB_IDX_SUPPLY_MON_A 3'h0
`define SSRB_IDX_REG_MON_B 3'h1
`define SSRB_IDX_REG_FAULT 3'h2
`define SSRB_IDX_CRC_WD 3'h3
`define SSRB_IDX_SELF_TEST 3'h4

// reset values
`define SSRB_RST_SUPPLY_MON_A 8'h00
`define SSRB_RST_REG_MON_B 8'h00
`define SSRB_RST_REG_FAULT 8'h00
`define SSRB_RST_CRC_WD 8'h05
`define SSRB_RST_SELF_TEST 8'h00

// supply_monitor_status_a fields
`define SSRB_A_REF_ERR_HIGH 0
`define SSRB_A_REF_ERR_LOW 1

// regulator_fault_status fields
`define SSRB_F_CAN_ILIM 7
`define SSRB_F_IO_ILIM 6
`define SSRB_F_SENS_UV 5
`define SSRB_F_SENS_OV 4
`define SSRB_F_RESERVED 3
`define SSRB_F_SENS_OT 2
`define SSRB_F_CAN_OT 1
`define SSRB_F_IO_OT 0
`define SSRB_F_USED_MASK 8'hF7

// crc_watchdog_status fields
`define SSRB_W_CFG_CRC_ERR 5
`define SSRB_W_NVM_CRC_ERR 4

// self_test_status fields
`define SSRB_S_LOGIC_ERR 4
`define SSRB_S_ANALOG_ERR_HI 3
`define SSRB_S_ANALOG_ERR_LO 2
`define SSRB_S_LOGIC_RUN 1
`define SSRB_S_ANALOG_RUN 0

// watchdog failure counter
`define SSRB_WD_DEFAULT 3'h5
`define SSRB_WD_MAX 3'h7
`define SSRB_WD_MIN 3'h0

// device state codes
`define SSRB_ST_DIAG 3'h7
`define SSRB_ST_ACTIVE 3'h5

// crc8 generator
`define SSRB_CRC_POLY 8'h07
`define SSRB_CRC_INIT 8'hFF

`endif

// ==== ssrb_cfg_crc.v ====
// crc8 check of the safety configuration bytes against the stored value
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_defines.vh"

module ssrb_cfg_crc #(
    parameter NBYTES = 10
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_enable,
    input wire [NBYTES*8-1:0] i_cfg_bytes,
    input wire [7:0] i_expected,
    output reg o_mismatch
);

    // one byte through the generator, msb first
    function [7:0] crc8_byte;
        input [7:0] crc_in;
        input [7:0] data;
        integer b;
        reg [7:0] c;
        begin
            c = crc_in ^ data;
            for (b = 0; b < 8; b = b + 1) begin
                if (c[7]) begin
                    c = {c[6:0], 1'b0} ^ `SSRB_CRC_POLY;
                end else begin
                    c = {c[6:0], 1'b0};
                end
            end
            crc8_byte = c;
        end
    endfunction

    reg [7:0] crc_calc;
    integer n;

    // whole chain in one cycle; the byte count is small so depth is acceptable
    always @* begin
        crc_calc = `SSRB_CRC_INIT;
        for (n = 0; n < NBYTES; n = n + 1) begin
            crc_calc = crc8_byte(crc_calc, i_cfg_bytes[n*8 +: 8]);
        end
    end

    // registered compare, idle when checking is switched off
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mismatch <= 1'b0;
        end else begin
            o_mismatch <= i_enable & (crc_calc != i_expected);
        end
    end

endmodule
`default_nettype wire

// ==== ssrb_wd_counter.v ====
// three-bit watchdog failure counter with reload on state entry
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_defines.vh"

module ssrb_wd_counter (
    input wire i_clk,
    input wire i_rst,
    input wire [2:0] i_dev_state,
    input wire i_wd_bad,
    input wire i_wd_good,
    output reg [2:0] o_count,
    output reg o_fail_pulse
);

    reg [2:0] state_prev_q;
    wire wd_entry;

    // entry into diagnostic or active seen as a change of state code
    assign wd_entry = (i_dev_state != state_prev_q) &&
                      ((i_dev_state == `SSRB_ST_DIAG) || (i_dev_state == `SSRB_ST_ACTIVE));

    // reload beats events; bad and good together leave the count alone
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_prev_q <= 3'h0;
            o_count <= `SSRB_WD_DEFAULT;
            o_fail_pulse <= 1'b0;
        end else begin
            state_prev_q <= i_dev_state;
            o_fail_pulse <= i_wd_bad & ~i_wd_good & (o_count == `SSRB_WD_MAX);
            if (wd_entry) begin
                o_count <= `SSRB_WD_DEFAULT;
            end else if (i_wd_bad && !i_wd_good && o_count != `SSRB_WD_MAX) begin
                o_count <= o_count + 3'h1;
            end else if (i_wd_good && !i_wd_bad && o_count != `SSRB_WD_MIN) begin
                o_count <= o_count - 3'h1;
            end
        end
    end

endmodule
`default_nettype wire

// ==== ssrb_bank.v ====
// safety status register bank: condition flags, crc, watchdog and self-test status
//
// Overview of operation
// - rail under/overvoltage flags follow their condition, clearing themselves without a read
// - reference error high flag is set while monitor reference exceeds main bandgap
// - CAN-rail current-limit flag follows the over-limit condition
// - I/O-rail current-limit flag follows the over-limit condition
// - sensor-supply undervoltage and overvoltage flags follow their conditions
// - fault bit 3 is reserved; sensor current limit only seen on diagnostic mux
// - sensor-supply overtemperature flag holds the sensor regulator disabled
// - CAN-rail overtemperature flag forces the CAN-rail enable control low
// - I/O-rail overtemperature flag holds the I/O regulator disabled
// - configuration crc error flag follows crc8 mismatch against stored value
// - clean nonvolatile crc check clears the configuration crc error flag
// - nonvolatile crc error flag set on mismatch; in diagnostic it requests safe state
// - watchdog failure counter resets to 5, reloads 5 entering diagnostic or active
// - counter counts up on bad watchdog answers, down on good ones
// - power stage enable output only when counter is below 5
// - bad answer with counter at 7 raises the watchdog fail event
// - analog self-test error in two bits, set on failure, cleared by read
// - logic self-test running flag is high while that test executes
// - analog self-test running flag is high while that test executes
// - a read returns the selected register byte with unused bits zero
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_defines.vh"

module ssrb_bank #(
    parameter CFG_BYTES = 10
) (
    input wire i_clk,
    input wire i_rst,
    // live conditions, one bit per flag, same bit order as the registers
    input wire [7:0] i_supply_mon_cond,
    input wire [7:0] i_reg_mon_cond,
    input wire i_can_rail_ilim,
    input wire i_io_rail_ilim,
    input wire i_sensor_uv,
    input wire i_sensor_ov,
    input wire i_sensor_ilim,
    input wire i_sensor_ot,
    input wire i_can_rail_ot,
    input wire i_io_rail_ot,
    // regulator control
    input wire i_can_rail_enable_req,
    // crc checks
    input wire i_cfg_crc_en,
    input wire [CFG_BYTES*8-1:0] i_cfg_bytes,
    input wire [7:0] i_cfg_crc_expected,
    input wire i_nvm_check_done,
    input wire i_nvm_crc_mismatch,
    // watchdog and device state
    input wire [2:0] i_dev_state,
    input wire i_wd_bad,
    input wire i_wd_good,
    input wire i_enable_drive_ctrl,
    // self-test
    input wire i_lbist_running,
    input wire i_lbist_done,
    input wire i_lbist_fail,
    input wire i_abist_running,
    input wire i_abist_fail,
    // register read port
    input wire i_rd_req,
    input wire [2:0] i_rd_sel,
    output reg [7:0] o_rd_data,
    output reg o_rd_valid,
    // device effects
    output reg o_can_rail_enable_control,
    output reg o_sensor_reg_disable,
    output reg o_io_reg_disable,
    output reg o_diagnostic_mux_output,
    output reg o_power_stage_enable_output,
    output reg o_watchdog_fail_pulse,
    output reg o_safe_state_req
);

    // flag registers
    reg [7:0] supply_mon_q;
    reg [7:0] reg_mon_q;
    reg [7:0] reg_fault_q;
    reg cfg_crc_err_q;
    reg nvm_crc_err_q;
    reg logic_err_q;
    reg logic_clean_q;
    reg analog_err_q;
    reg logic_run_q;
    reg analog_run_q;

    reg cfg_crc_err_d;
    reg nvm_crc_err_d;
    reg logic_err_d;
    reg logic_clean_d;
    reg analog_err_d;

    wire cfg_mismatch;
    wire [2:0] wd_count;
    wire watchdog_fail_flag;
    wire in_diag;
    wire self_test_read;
    wire nvm_clean;
    // derived terms for the drive and safe-state outputs
    wire wd_below_default;
    wire nvm_err_rise;
    wire analog_err_rise;

    // state, read and nvm-check decodes for the flags and the safe-state request
    assign in_diag = (i_dev_state == `SSRB_ST_DIAG);
    assign self_test_read = i_rd_req && (i_rd_sel == `SSRB_IDX_SELF_TEST);
    assign nvm_clean = i_nvm_check_done & ~i_nvm_crc_mismatch;

    ssrb_cfg_crc #(
        .NBYTES(CFG_BYTES)
    ) u_cfg_crc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_enable(i_cfg_crc_en),
        .i_cfg_bytes(i_cfg_bytes),
        .i_expected(i_cfg_crc_expected),
        .o_mismatch(cfg_mismatch)
    );

    ssrb_wd_counter u_wd (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_dev_state(i_dev_state),
        .i_wd_bad(i_wd_bad),
        .i_wd_good(i_wd_good),
        .o_count(wd_count),
        .o_fail_pulse(watchdog_fail_flag)
    );

    // assemble the read byte; reserved positions stay zero
    function [7:0] read_mux;
        input [2:0] sel;
        input [7:0] mon_a;
        input [7:0] mon_b;
        input [7:0] fault;
        input [7:0] crc_wd;
        input [7:0] stest;
        begin
            case (sel)
                `SSRB_IDX_SUPPLY_MON_A: read_mux = mon_a;
                `SSRB_IDX_REG_MON_B: read_mux = mon_b;
                `SSRB_IDX_REG_FAULT: read_mux = fault & `SSRB_F_USED_MASK;
                `SSRB_IDX_CRC_WD: read_mux = crc_wd;
                `SSRB_IDX_SELF_TEST: read_mux = stest;
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    // read bytes built from the flags
    wire [7:0] crc_wd_byte;
    wire [7:0] self_test_byte;

    // upper bits 7:6 and bit 3 read zero
    assign crc_wd_byte = {2'b00, cfg_crc_err_q, nvm_crc_err_q, 1'b0, wd_count};
    // reset-feedback error is kept elsewhere, so bit 5 reads zero here
    assign self_test_byte = {3'b000, logic_err_q, analog_err_q, analog_err_q,
                             logic_run_q, analog_run_q};

    // condition-following monitor bytes, all sampled on the same edge
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            supply_mon_q <= `SSRB_RST_SUPPLY_MON_A;
            reg_mon_q <= `SSRB_RST_REG_MON_B;
        end else begin
            supply_mon_q <= i_supply_mon_cond;
            reg_mon_q <= i_reg_mon_cond;
        end
    end

    // fault byte and run flags; no latching, a flag drops with its condition
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            reg_fault_q <= `SSRB_RST_REG_FAULT;
            logic_run_q <= 1'b0;
            analog_run_q <= 1'b0;
        end else begin
            reg_fault_q[`SSRB_F_CAN_ILIM] <= i_can_rail_ilim;
            reg_fault_q[`SSRB_F_IO_ILIM] <= i_io_rail_ilim;
            reg_fault_q[`SSRB_F_SENS_UV] <= i_sensor_uv;
            reg_fault_q[`SSRB_F_SENS_OV] <= i_sensor_ov;
            reg_fault_q[`SSRB_F_RESERVED] <= 1'b0;
            reg_fault_q[`SSRB_F_SENS_OT] <= i_sensor_ot;
            reg_fault_q[`SSRB_F_CAN_OT] <= i_can_rail_ot;
            reg_fault_q[`SSRB_F_IO_OT] <= i_io_rail_ot;
            logic_run_q <= i_lbist_running;
            analog_run_q <= i_abist_running;
        end
    end

    // next values of event and crc flags
    always @* begin
        // a clean nonvolatile check wins over a standing config mismatch this cycle
        cfg_crc_err_d = cfg_mismatch & ~nvm_clean;
        nvm_crc_err_d = nvm_crc_err_q;
        if (i_nvm_check_done) begin
            nvm_crc_err_d = i_nvm_crc_mismatch;
        end
        // clear on read, but a failure in the same cycle is kept
        analog_err_d = analog_err_q;
        if (self_test_read) begin
            analog_err_d = 1'b0;
        end
        if (i_abist_fail) begin
            analog_err_d = 1'b1;
        end
        // logic error needs a clean run before a read may clear it
        logic_clean_d = logic_clean_q;
        logic_err_d = logic_err_q;
        if (i_lbist_done && !i_lbist_fail) begin
            logic_clean_d = 1'b1;
        end
        if (self_test_read && logic_clean_q) begin
            logic_err_d = 1'b0;
            logic_clean_d = 1'b0;
        end
        if (i_lbist_fail) begin
            logic_err_d = 1'b1;
            logic_clean_d = 1'b0;
        end
    end

    // crc flags
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_crc_err_q <= 1'b0;
            nvm_crc_err_q <= 1'b0;
        end else begin
            cfg_crc_err_q <= cfg_crc_err_d;
            nvm_crc_err_q <= nvm_crc_err_d;
        end
    end

    // self-test error flags and the clean-run arm
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            analog_err_q <= 1'b0;
            logic_err_q <= 1'b0;
            logic_clean_q <= 1'b0;
        end else begin
            analog_err_q <= analog_err_d;
            logic_err_q <= logic_err_d;
            logic_clean_q <= logic_clean_d;
        end
    end

    // read answer: one-cycle valid, data held until the next read
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_req;
            if (i_rd_req) begin
                o_rd_data <= read_mux(i_rd_sel, supply_mon_q, reg_mon_q, reg_fault_q,
                                      crc_wd_byte, self_test_byte);
            end
        end
    end

    // regulator shutdown and drive outputs; shutdowns from the registered flags, mux from the raw i_sensor_ilim
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_can_rail_enable_control <= 1'b0;
            o_sensor_reg_disable <= 1'b0;
            o_io_reg_disable <= 1'b0;
            o_diagnostic_mux_output <= 1'b0;
        end else begin
            o_can_rail_enable_control <= i_can_rail_enable_req &
                                         ~reg_fault_q[`SSRB_F_CAN_OT];
            o_sensor_reg_disable <= reg_fault_q[`SSRB_F_SENS_OT];
            o_io_reg_disable <= reg_fault_q[`SSRB_F_IO_OT];
            o_diagnostic_mux_output <= i_sensor_ilim;
        end
    end

    // counter must have come down below its default before the stage drives
    assign wd_below_default = (wd_count < `SSRB_WD_DEFAULT);
    // fresh failures that push a diagnostic device to the safe state
    assign nvm_err_rise = nvm_crc_err_d & ~nvm_crc_err_q;
    assign analog_err_rise = analog_err_d & ~analog_err_q;

    // watchdog-driven outputs and the safe-state request
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_power_stage_enable_output <= 1'b0;
            o_watchdog_fail_pulse <= 1'b0;
            o_safe_state_req <= 1'b0;
        end else begin
            // enable bit alone is not enough
            o_power_stage_enable_output <= i_enable_drive_ctrl & wd_below_default;
            o_watchdog_fail_pulse <= watchdog_fail_flag;
            o_safe_state_req <= in_diag & (nvm_err_rise | analog_err_rise);
        end
    end

endmodule
`default_nettype wire

// ==== ssrb_bank_assertions.sv ====
// concurrent checks on the safety status bank ports
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_defines.vh"
module ssrb_bank_chk (
    input wire i_clk,
    input wire i_rst,
    input wire [7:0] i_supply_mon_cond,
    input wire [7:0] i_reg_mon_cond,
    input wire i_sensor_ilim,
    input wire i_sensor_ot,
    input wire i_can_rail_ot,
    input wire i_io_rail_ot,
    input wire i_rd_req,
    input wire [2:0] i_rd_sel,
    input wire [2:0] i_dev_state,
    input wire i_wd_bad,
    input wire i_enable_drive_ctrl,
    input wire [7:0] o_rd_data,
    input wire o_rd_valid,
    input wire o_can_rail_enable_control,
    input wire o_sensor_reg_disable,
    input wire o_io_reg_disable,
    input wire o_diagnostic_mux_output,
    input wire o_power_stage_enable_output,
    input wire o_watchdog_fail_pulse,
    input wire o_safe_state_req
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // edges since release, so the gated $past checks never look back into reset
    logic [1:0] up_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) up_q <= 2'h0;
        else up_q <= {up_q[0], 1'b1};
    end
    a_read_answered: assert property (i_rd_req |=> o_rd_valid)
        else $error("read not answered");
    a_valid_uncaused: assert property (!i_rd_req |=> !o_rd_valid)
        else $error("answer without read");
    a_supply_snap: assert property (up_q[1] && i_rd_req && i_rd_sel == 3'h0
        |=> o_rd_data == $past(i_supply_mon_cond, 2)) else $error("supply byte wrong");
    a_regmon_snap: assert property (up_q[1] && i_rd_req && i_rd_sel == 3'h1
        |=> o_rd_data == $past(i_reg_mon_cond, 2)) else $error("regulator byte wrong");
    a_unmapped_zero: assert property (i_rd_req && i_rd_sel > 3'h4
        |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
    a_reserved_zero: assert property (i_rd_req && i_rd_sel == 3'h2
        |=> !o_rd_data[3]) else $error("reserved fault bit set");
    a_sensor_off: assert property (up_q[1]
        |-> o_sensor_reg_disable == $past(i_sensor_ot, 2)) else $error("sensor disable wrong");
    a_io_off: assert property (up_q[1]
        |-> o_io_reg_disable == $past(i_io_rail_ot, 2)) else $error("io disable wrong");
    a_can_forced_off: assert property (up_q[1] && $past(i_can_rail_ot, 2)
        |-> !o_can_rail_enable_control) else $error("can rail left enabled");
    a_mux_follows: assert property (up_q[0]
        |-> o_diagnostic_mux_output == $past(i_sensor_ilim)) else $error("mux wrong");
    a_stage_gated: assert property (o_power_stage_enable_output
        |-> $past(i_enable_drive_ctrl)) else $error("stage enabled without control");
    a_fail_cause: assert property (o_watchdog_fail_pulse |-> $past(i_wd_bad, 2))
        else $error("fail without bad answer");
    a_safe_in_diag: assert property (o_safe_state_req
        |-> $past(i_dev_state) == `SSRB_ST_DIAG) else $error("safe request outside diag");
    c_fail: cover property (o_watchdog_fail_pulse);
    c_safe: cover property (o_safe_state_req);
    c_stage: cover property (o_power_stage_enable_output);
endmodule
bind ssrb_bank ssrb_bank_chk i_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_supply_mon_cond(i_supply_mon_cond), .i_reg_mon_cond(i_reg_mon_cond),
    .i_sensor_ilim(i_sensor_ilim), .i_sensor_ot(i_sensor_ot), .i_can_rail_ot(i_can_rail_ot),
    .i_io_rail_ot(i_io_rail_ot), .i_rd_req(i_rd_req), .i_rd_sel(i_rd_sel),
    .i_dev_state(i_dev_state), .i_wd_bad(i_wd_bad), .i_enable_drive_ctrl(i_enable_drive_ctrl),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_can_rail_enable_control(o_can_rail_enable_control),
    .o_sensor_reg_disable(o_sensor_reg_disable), .o_io_reg_disable(o_io_reg_disable),
    .o_diagnostic_mux_output(o_diagnostic_mux_output),
    .o_power_stage_enable_output(o_power_stage_enable_output),
    .o_watchdog_fail_pulse(o_watchdog_fail_pulse), .o_safe_state_req(o_safe_state_req));
`default_nettype wire

// ==== ssrb_host.sv ====
// reader model standing where the microcontroller sits on the read port
`timescale 1ns/1ps
`default_nettype none
module ssrb_host (
    input wire logic i_clk,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    output logic o_rd_req,
    output logic [2:0] o_rd_sel
);
    initial begin
        o_rd_req = 1'b0;
        o_rd_sel = 3'h0;
    end
    // one byte per read; select scrambled once taken so no stale value lingers
    task read(input [2:0] s, output [7:0] d, output ok);
        integer n;
        begin
            ok = 1'b0;
            o_rd_req <= 1'b1;
            o_rd_sel <= s;
            @(posedge i_clk);
            o_rd_req <= 1'b0;
            o_rd_sel <= ~s;
            for (n = 0; n < 4 && !ok; n++) begin
                #1;
                if (i_rd_valid === 1'b1) begin
                    d = i_rd_data;
                    ok = 1'b1;
                end else @(posedge i_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== ssrb_tb.sv ====
// self-checking bench for the safety status bank
`timescale 1ns/1ps
`default_nettype none
`include "ssrb_defines.vh"
module testbench;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_supply_mon_cond = 8'h00, i_reg_mon_cond = 8'h00, flt = 8'h00;
    logic [7:0] i_cfg_crc_expected = 8'h00;
    logic [79:0] i_cfg_bytes = 80'h0;
    logic [2:0] i_dev_state = 3'h0;
    logic [5:0] p = 6'h00; // pulses: bad, good, nvm done, logic done, logic fail, analog fail
    logic can_en = 1'b0, cfg_en = 1'b0, nvm_mm = 1'b0, en_drv = 1'b0, lrun = 1'b0, arun = 1'b0;
    wire i_rd_req, o_rd_valid, o_can, o_sens, o_io, o_mux, o_stage, o_fail, o_safe;
    wire [2:0] i_rd_sel;
    wire [7:0] o_rd_data;
    integer seed = 59, bad_count = 0, check_count = 0, n;
    logic [3:0] k;
    logic seen;
    always #12.5 i_clk = ~i_clk;
    ssrb_bank i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_supply_mon_cond(i_supply_mon_cond),
        .i_reg_mon_cond(i_reg_mon_cond), .i_can_rail_ilim(flt[7]), .i_io_rail_ilim(flt[6]),
        .i_sensor_uv(flt[5]), .i_sensor_ov(flt[4]), .i_sensor_ilim(flt[3]), .i_sensor_ot(flt[2]),
        .i_can_rail_ot(flt[1]), .i_io_rail_ot(flt[0]), .i_can_rail_enable_req(can_en),
        .i_cfg_crc_en(cfg_en), .i_cfg_bytes(i_cfg_bytes), .i_cfg_crc_expected(i_cfg_crc_expected),
        .i_nvm_check_done(p[3]), .i_nvm_crc_mismatch(nvm_mm), .i_dev_state(i_dev_state),
        .i_wd_bad(p[5]), .i_wd_good(p[4]), .i_enable_drive_ctrl(en_drv), .i_lbist_running(lrun),
        .i_lbist_done(p[2]), .i_lbist_fail(p[1]), .i_abist_running(arun), .i_abist_fail(p[0]),
        .i_rd_req(i_rd_req), .i_rd_sel(i_rd_sel), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .o_can_rail_enable_control(o_can), .o_sensor_reg_disable(o_sens), .o_io_reg_disable(o_io),
        .o_diagnostic_mux_output(o_mux), .o_power_stage_enable_output(o_stage),
        .o_watchdog_fail_pulse(o_fail), .o_safe_state_req(o_safe));
    ssrb_host i_host (.i_clk(i_clk), .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data),
        .o_rd_req(i_rd_req), .o_rd_sel(i_rd_sel));
    // reference crc8, msb first, byte 0 first
    function [7:0] crc8(input [79:0] b);
        integer i, j;
        reg [7:0] c;
        begin
            c = 8'hFF;
            for (i = 0; i < 10; i++) begin
                c = c ^ b[8*i+:8];
                for (j = 0; j < 8; j++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
            end
            crc8 = c;
        end
    endfunction
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input [7:0] s, input [7:0] e);
        begin
            check_count++;
            if (s !== e) begin
                bad_count++;
                $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
            end
        end
    endtask
    // read one register; a missing answer ends the run
    task rc(input [2:0] s, input [7:0] e);
        reg [7:0] d;
        reg ok;
        begin
            i_host.read(s, d, ok);
            if (!ok) begin
                bad_count++;
                tally_and_finish;
            end
            chk(d, e);
        end
    endtask
    task pulse(input [5:0] m);
        begin
            p <= m;
            @(posedge i_clk);
            p <= 6'h00;
        end
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        for (k = 0; k < 8; k++) rc(k[2:0], k == 3 ? `SSRB_RST_CRC_WD : 8'h00);
        // random conditions, all-ones first; can enable checked as the request gated by can-rail overtemperature
        for (n = 0; n < 16; n++) begin
            i_supply_mon_cond <= n == 0 ? 8'hFF : 8'($random(seed));
            i_reg_mon_cond <= n == 0 ? 8'hFF : 8'($random(seed));
            flt <= n == 0 ? 8'hFF : 8'($random(seed));
            can_en <= 1'($random(seed));
            @(posedge i_clk);
            rc(3'h0, i_supply_mon_cond);
            rc(3'h1, i_reg_mon_cond);
            rc(3'h2, flt & `SSRB_F_USED_MASK);
            chk({4'h0, o_can, o_sens, o_io, o_mux},
                {4'h0, can_en & ~flt[1], flt[2], flt[0], flt[3]});
        end
        // watchdog counter: floor, gate, saturation, fail event
        i_dev_state <= `SSRB_ST_ACTIVE;
        en_drv <= 1'b1;
        repeat (2) @(posedge i_clk);
        p <= 6'h10; // six good answers on back-to-back edges
        repeat (6) @(posedge i_clk);
        p <= 6'h00;
        rc(3'h3, 8'h00);
        chk({7'h00, o_stage}, 8'h01);
        p <= 6'h20; // eight bad answers, the last one at the ceiling
        repeat (8) @(posedge i_clk);
        p <= 6'h00;
        rc(3'h3, 8'h07);
        chk({7'h00, o_stage}, 8'h00);
        pulse(6'h20);
        seen = 1'b0;
        repeat (3) begin
            @(posedge i_clk);
            #1;
            if (o_fail === 1'b1) seen = 1'b1;
        end
        chk({7'h00, seen}, 8'h01);
        i_dev_state <= `SSRB_ST_DIAG;
        repeat (2) @(posedge i_clk);
        rc(3'h3, 8'h05);
        // configuration and nonvolatile crc flags
        i_cfg_bytes <= {$random(seed), $random(seed), 16'($random(seed))};
        @(posedge i_clk);
        i_cfg_crc_expected <= crc8(i_cfg_bytes);
        cfg_en <= 1'b1;
        repeat (4) @(posedge i_clk);
        rc(3'h3, 8'h05);
        i_cfg_crc_expected <= crc8(i_cfg_bytes) ^ 8'h01;
        repeat (4) @(posedge i_clk);
        rc(3'h3, 8'h25);
        nvm_mm <= 1'b1;
        pulse(6'h08);
        #1;
        chk({7'h00, o_safe}, 8'h01);
        rc(3'h3, 8'h35);
        nvm_mm <= 1'b0;
        pulse(6'h08);
        rc(3'h3, 8'h05);
        rc(3'h3, 8'h25);
        // self-test running and error flags
        lrun <= 1'b1;
        arun <= 1'b1;
        @(posedge i_clk);
        rc(3'h4, 8'h03);
        lrun <= 1'b0;
        arun <= 1'b0;
        @(posedge i_clk);
        rc(3'h4, 8'h00);
        pulse(6'h01);
        #1;
        chk({7'h00, o_safe}, 8'h01);
        rc(3'h4, 8'h0C);
        rc(3'h4, 8'h00);
        pulse(6'h02);
        rc(3'h4, 8'h10);
        rc(3'h4, 8'h10);
        pulse(6'h04);
        rc(3'h4, 8'h10);
        rc(3'h4, 8'h00);
        tally_and_finish;
    end
endmodule
`default_nettype wire
